/* logic/idregs_cfg.svh */
/*
 Offsets, field positions, fixed values and timing counts of the
 identity, scratch and flash-count register bank.
 Assumes a 10 MHz system clock and byte addresses of the serial port.
*/
// Summary of operation
// - day-month register upper byte reads factory month as two BCD digits
// - day-month register lower byte reads factory day as two BCD digits
// - year register reads four BCD year digits, read only
// - product code reads a fixed 16-bit value on every read
// - serial register reads a fixed 16-bit lot serial number
// - three read/write scratch words read back exactly as written
// - a 32-bit binary count of flash write cycles, two read-only words
// - lower address holds count bits 15:0, next address bits 31:16
// - after flash update, status bit 2 reads 0 on success, 1 on failure
// - while flash update runs, serial requests are ignored
`ifndef IDREGS_CFG_SVH
`define IDREGS_CFG_SVH

`define FACTORY_DAY_MONTH_ADDR 7'h6e
`define FACTORY_YEAR_ADDR      7'h70
`define PRODUCT_CODE_ADDR      7'h72
`define LOT_SERIAL_ADDR        7'h74
`define SCRATCH_ONE_ADDR       7'h76
`define SCRATCH_TWO_ADDR       7'h78
`define SCRATCH_THREE_ADDR     7'h7a
`define FLASH_WRITES_LOW_ADDR  7'h7c
`define FLASH_WRITES_HIGH_ADDR 7'h7e
`define GLOBAL_COMMAND_ADDR    7'h68
`define DIAG_STATUS_ADDR       7'h5c

`define FLASH_UPDATE_BIT       3
`define DIAG_FLASH_FAIL_BIT    2

// arbitrary values, replaced at factory configuration
`define FACTORY_DAY_MONTH_VAL  16'h0101
`define FACTORY_YEAR_VAL       16'h2000
`define PRODUCT_CODE_VAL       16'h1234
`define LOT_SERIAL_VAL         16'h0001

`define CLK_PERIOD_NS          100
`define FLASH_UPDATE_NS        1000
`define FLASH_UPDATE_CYCLES \
	((`FLASH_UPDATE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* logic/idregs_pkg.sv */
/*
 Types shared by the register bank and its flash writer.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package idregs_pkg;
	typedef logic [15:0] word_t;
	typedef logic [6:0]  byte_addr_t;
	typedef enum logic {FW_IDLE, FW_WRITE} flash_state_e;
endpackage

/* logic/flash_ctl_if.sv */
/*
 Interface between the register bank and the flash writer.
 Assumes one clock domain shared by both ends.
*/
`timescale 1ns/1ps
interface flash_ctl_if;
	logic        start;
	logic        busy;
	logic        done;
	logic        failed;
	logic [31:0] count;
	modport bank   (output start, input busy, done, failed, count);
	modport writer (input start, output busy, done, failed, count);
endinterface

/* logic/flash_writer.sv */
/*
 Flash update sequencer: holds busy for the update time, then counts
 the write cycle and records its outcome.
 Assumes the flash macro reports failure on flash_fail at the end.
*/
`timescale 1ns/1ps
`include "idregs_cfg.svh"
module flash_writer
	import idregs_pkg::*;
(
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_b,
	input  wire logic ce,
	// flash macro result
	input  wire logic flash_fail,
	// bank side
	flash_ctl_if.writer fl
);
	localparam logic [7:0] LAST = 8'(`FLASH_UPDATE_CYCLES - 1);

	flash_state_e state;
	logic [7:0]   timer;
	logic         finish;

	assign finish  = (state == FW_WRITE) && (timer == LAST);
	assign fl.busy = (state == FW_WRITE);

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state <= FW_IDLE;
			timer <= 8'h00;
		end else if (ce) begin
			case (state)
			FW_IDLE: begin
				timer <= 8'h00;
				if (fl.start)
					state <= FW_WRITE;
			end
			FW_WRITE: begin
				timer <= timer + 8'h01;
				if (finish)
					state <= FW_IDLE;
			end
			default: state <= FW_IDLE;
			endcase
		end
	end

	// count and outcome move together so software never sees them split
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			fl.count  <= 32'h0000_0000;
			fl.failed <= 1'b0;
			fl.done   <= 1'b0;
		end else if (ce) begin
			fl.done <= finish;
			if (finish) begin
				fl.count  <= fl.count + 32'h0000_0001;
				fl.failed <= flash_fail;
			end
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	property p_count_step;
		ce && finish |=> fl.count == $past(fl.count) + 32'h0000_0001;
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("flash count did not advance by one");

	property p_fail_flag;
		ce && finish |=> fl.done && fl.failed == $past(flash_fail);
	endproperty
	a_fail_flag: assert property (p_fail_flag)
		else $error("flash outcome not recorded at completion");

	cv_fail: cover property (ce && finish && flash_fail);
endmodule

/* logic/idregs_bank.sv */
/*
 Identity, scratch and flash write count registers behind the serial
 port's byte-wide register access, with the flash update command.
 Assumes the serial port hands over one byte write or one word read
 per request, addresses in bytes, synchronous to clk_sys.
*/
`timescale 1ns/1ps
`include "idregs_cfg.svh"
module idregs_bank
	import idregs_pkg::*;
(
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_b,
	input  wire logic       ce,
	// register access from the serial port
	input  wire logic       req_valid,
	input  wire logic       req_write,
	input  wire byte_addr_t req_addr,
	input  wire logic [7:0] req_wdata,
	output logic            req_ready,
	output word_t           rd_data,
	output logic            rd_valid,
	// flash macro and status
	input  wire logic       flash_fail,
	output logic            flash_busy,
	output logic            flash_update_failed
);
	flash_ctl_if fl ();

	flash_writer u_writer (
		.clk_sys    (clk_sys),
		.rst_b      (rst_b),
		.ce         (ce),
		.flash_fail (flash_fail),
		.fl         (fl.writer)
	);

	word_t      scratch [0:2];
	logic       taken;
	logic       do_write;
	logic       do_read;
	logic       in_scratch;
	logic [6:0] scr_off;
	logic [1:0] scr_idx;
	word_t      diag_word;
	word_t      next_rd_data;

	function automatic word_t merge_byte(input word_t old,
			input logic hi, input logic [7:0] b);
		merge_byte = hi ? {b, old[7:0]} : {old[15:8], b};
	endfunction

	function automatic logic at(input byte_addr_t a, input byte_addr_t w);
		at = (a[6:1] == w[6:1]);
	endfunction

	// requests during an update are dropped, not queued
	assign req_ready  = !fl.busy;
	assign taken      = ce && req_valid && req_ready;
	assign do_write   = taken && req_write;
	assign do_read    = taken && !req_write;
	assign in_scratch = (req_addr >= `SCRATCH_ONE_ADDR) &&
		(req_addr <= (`SCRATCH_THREE_ADDR | 7'h01));
	assign scr_off    = req_addr - `SCRATCH_ONE_ADDR;
	assign scr_idx    = scr_off[2:1];
	// global command low byte, only the flash update bit is acted on
	assign fl.start   = do_write && (req_addr == `GLOBAL_COMMAND_ADDR) &&
		req_wdata[`FLASH_UPDATE_BIT];
	assign diag_word  = word_t'(fl.failed) << `DIAG_FLASH_FAIL_BIT;

	assign flash_busy          = fl.busy;
	assign flash_update_failed = fl.failed;

	// read-only words are constants or the writer's count and outcome, so writes to them fall through
	assign next_rd_data =
		at(req_addr, `FACTORY_DAY_MONTH_ADDR) ? `FACTORY_DAY_MONTH_VAL :
		at(req_addr, `FACTORY_YEAR_ADDR)      ? `FACTORY_YEAR_VAL :
		at(req_addr, `PRODUCT_CODE_ADDR)      ? `PRODUCT_CODE_VAL :
		at(req_addr, `LOT_SERIAL_ADDR)        ? `LOT_SERIAL_VAL :
		in_scratch                            ? scratch[scr_idx] :
		at(req_addr, `FLASH_WRITES_LOW_ADDR)  ? fl.count[15:0] :
		at(req_addr, `FLASH_WRITES_HIGH_ADDR) ? fl.count[31:16] :
		at(req_addr, `DIAG_STATUS_ADDR)       ? diag_word :
		16'h0000;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rd_data  <= 16'h0000;
			rd_valid <= 1'b0;
		end else if (ce) begin
			rd_valid <= do_read;
			if (do_read)
				rd_data <= next_rd_data;
		end
	end

	// scratch lives in flops; keeping it over power loss is the
	// host's flash update, which this bank only triggers
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < 3; i++)
				scratch[i] <= 16'h0000;
		end else if (do_write && in_scratch) begin
			scratch[scr_idx] <= merge_byte(scratch[scr_idx], req_addr[0],
				req_wdata);
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	property p_busy_drop;
		fl.busy && ce && req_valid |=> !rd_valid;
	endproperty
	a_busy_drop: assert property (p_busy_drop)
		else $error("request answered during flash update");

	property p_start_busy;
		fl.start && !fl.busy |=> fl.busy;
	endproperty
	a_start_busy: assert property (p_start_busy)
		else $error("flash update did not start");

	property p_day_month;
		do_read && req_addr[6:1] == 6'h37 |=>
			rd_valid && rd_data[15:8] == 8'h01 && rd_data[7:0] == 8'h01;
	endproperty
	a_day_month: assert property (p_day_month)
		else $error("day-month word wrong");

	property p_year;
		do_read && req_addr[6:1] == 6'h38 |=> rd_data == 16'h2000;
	endproperty
	a_year: assert property (p_year)
		else $error("year word wrong");

	property p_product;
		do_read && req_addr[6:1] == 6'h39 |=>
			rd_valid && rd_data == 16'h1234;
	endproperty
	a_product: assert property (p_product)
		else $error("product code wrong");

	property p_serial;
		do_read && req_addr[6:1] == 6'h3a |=> rd_data == 16'h0001;
	endproperty
	a_serial: assert property (p_serial)
		else $error("serial word wrong");

	property p_scratch_low;
		do_write && req_addr == 7'h76 |=>
			scratch[0][7:0] == $past(req_wdata) &&
			scratch[0][15:8] == $past(scratch[0][15:8]);
	endproperty
	a_scratch_low: assert property (p_scratch_low)
		else $error("scratch byte not stored");

	property p_count_low;
		do_read && req_addr[6:1] == 6'h3e && !fl.done |=>
			rd_data == fl.count[15:0];
	endproperty
	a_count_low: assert property (p_count_low)
		else $error("count low word wrong");

	property p_count_high;
		do_read && req_addr[6:1] == 6'h3f && !fl.done |=>
			rd_data == fl.count[31:16];
	endproperty
	a_count_high: assert property (p_count_high)
		else $error("count high word wrong");

	property p_ro_write;
		do_write && req_addr[6:1] == 6'h3e && !fl.done |=>
			$stable(fl.count);
	endproperty
	a_ro_write: assert property (p_ro_write)
		else $error("write changed read-only count");

	property p_scratch_top;
		do_write && req_addr == 7'h7b |=>
			scratch[2][15:8] == $past(req_wdata) &&
			scratch[2][7:0] == $past(scratch[2][7:0]);
	endproperty
	a_scratch_top: assert property (p_scratch_top)
		else $error("scratch upper byte not stored");

	property p_scratch_read;
		do_read && req_addr[6:1] == 6'h3c |=>
			rd_valid && rd_data == $past(scratch[1]);
	endproperty
	a_scratch_read: assert property (p_scratch_read)
		else $error("scratch word not returned");

	// writes outside the scratch window never touch scratch
	property p_scratch_keep;
		do_write && !in_scratch |=>
			scratch[0] == $past(scratch[0]) &&
			scratch[1] == $past(scratch[1]) &&
			scratch[2] == $past(scratch[2]);
	endproperty
	a_scratch_keep: assert property (p_scratch_keep)
		else $error("write outside scratch changed scratch");

	property p_diag;
		do_read && req_addr[6:1] == 6'h2e |=>
			rd_data == {13'h0, $past(fl.failed), 2'h0};
	endproperty
	a_diag: assert property (p_diag)
		else $error("status word wrong");

	property p_cmd_other;
		do_write && req_addr == 7'h68 && !req_wdata[3] && !fl.busy |=>
			!fl.busy;
	endproperty
	a_cmd_other: assert property (p_cmd_other)
		else $error("update started without its command bit");

	// ten busy cycles at 100 ns; a frozen clock enable stretches it
	property p_busy_len;
		disable iff (!rst_b || !ce)
		$rose(fl.busy) |-> fl.busy [*8] ##1 fl.busy [*2] ##1 !fl.busy;
	endproperty
	a_busy_len: assert property (p_busy_len)
		else $error("update busy time wrong");

	property p_rd_hold;
		!do_read |=> $stable(rd_data);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read data moved without a read");

	cv_update:  cover property (fl.start ##1 fl.busy [*3]);
	cv_scratch: cover property (do_write && in_scratch ##1 do_read);
	cv_drop:    cover property (fl.busy && req_valid);
	cv_freeze:  cover property (!ce && req_valid);
endmodule

/* test/host_model.sv */
/*
 Host model: issues byte writes and word reads on the register port.
 Assumes one clock shared with the bank; drives 1 ns after the edge.
*/
`timescale 1ns/1ps
module host_model
	import idregs_pkg::*;
(
	// clock
	input  wire logic       clk_sys,
	// register port
	output logic            req_valid,
	output logic            req_write,
	output byte_addr_t      req_addr,
	output logic [7:0]      req_wdata,
	input  wire logic       req_ready,
	input  wire word_t      rd_data,
	input  wire logic       rd_valid
);
	initial begin
		req_valid = 1'b0;
		req_write = 1'b0;
		req_addr = 7'h00;
		req_wdata = 8'h00;
	end

	// wait_rdy low: one cycle only, so a busy bank drops it
	task automatic xfer(input logic w, input byte_addr_t a,
		input logic [7:0] d, input bit wait_rdy,
		output word_t q, output logic v);
		@(posedge clk_sys);
		#1;
		req_valid = 1'b1;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		@(negedge clk_sys);
		while (wait_rdy && !req_ready) @(negedge clk_sys);
		@(posedge clk_sys);
		#1;
		q = rd_data;
		v = rd_valid;
		// released lines show garbage, not the last value
		req_valid = 1'b0;
		req_addr = ~a;
		req_wdata = ~d;
	endtask
endmodule

/* test/tb_top.sv */
/*
 Self-checking bench of the register bank against an integer model.
 Assumes host_model as the serial-port side and a 10 MHz clock.
*/
`timescale 1ns/1ps
`include "idregs_cfg.svh"
module tb_top;
	import idregs_pkg::*;
	logic       clk_sys, rst_b, ce, flash_fail;
	logic       req_valid, req_write, req_ready, rd_valid;
	logic       flash_busy, flash_update_failed;
	byte_addr_t req_addr;
	logic [7:0] req_wdata;
	word_t      rd_data, q;
	logic       v;
	int         error_cnt, num_checks, n;
	logic [31:0] rng, cnt;
	word_t      scr [$];

	idregs_bank dut (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce),
		.req_valid(req_valid), .req_write(req_write),
		.req_addr(req_addr), .req_wdata(req_wdata),
		.req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid),
		.flash_fail(flash_fail), .flash_busy(flash_busy),
		.flash_update_failed(flash_update_failed));
	host_model host (.clk_sys(clk_sys), .req_valid(req_valid),
		.req_write(req_write), .req_addr(req_addr),
		.req_wdata(req_wdata), .req_ready(req_ready),
		.rd_data(rd_data), .rd_valid(rd_valid));

	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic check(input string nm, input word_t s, input word_t e);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic rd(input byte_addr_t a, input word_t e);
		host.xfer(1'b0, a, 8'h00, 1'b1, q, v);
		check("rd_valid", {15'h0, v}, 16'h0001);
		check($sformatf("read %h", a), q, e);
	endtask

	task automatic wr(input byte_addr_t a, input word_t d);
		host.xfer(1'b1, a, d[7:0], 1'b1, q, v);
		host.xfer(1'b1, a + 7'h1, d[15:8], 1'b1, q, v);
	endtask

	task automatic update(input logic f);
		flash_fail = f;
		host.xfer(1'b1, 7'h68, 8'h08, 1'b1, q, v);
		check("busy", {15'h0, flash_busy}, 16'h0001);
		host.xfer(1'b1, 7'h76, ~scr[0][7:0], 1'b0, q, v);
		host.xfer(1'b0, 7'h72, 8'h00, 1'b0, q, v);
		check("drop", {15'h0, v}, 16'h0000);
		n = 0;
		while (flash_busy && n < 50) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		check("idle", {15'h0, flash_busy}, 16'h0000);
		cnt = cnt + 1;
		rd(7'h7c, cnt[15:0]);
		rd(7'h7e, cnt[31:16]);
		rd(7'h5c, {13'h0, f, 2'h0});
		rd(7'h76, scr[0]);
	endtask

	task automatic end_of_test;
		if (error_cnt == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// far beyond the hundred or so cycles the sequence needs
	initial begin
		#500000;
		error_cnt++;
		end_of_test;
	end

	initial begin
		rst_b = 1'b0;
		ce = 1'b1;
		flash_fail = 1'b0;
		rng = 32'h26;
		cnt = 0;
		repeat (16) @(posedge clk_sys);
		#1;
		rst_b = 1'b1;
		rd(7'h6e, `FACTORY_DAY_MONTH_VAL);
		rd(7'h70, `FACTORY_YEAR_VAL);
		rd(7'h72, `PRODUCT_CODE_VAL);
		rd(7'h72, `PRODUCT_CODE_VAL);
		rd(7'h74, `LOT_SERIAL_VAL);
		rd(7'h00, 16'h0000);
		for (int i = 0; i < 3; i++) begin
			rng = xs(rng);
			scr.push_back(rng[15:0]);
			wr(7'h76 + 7'(2 * i), scr[i]);
		end
		for (int i = 0; i < 3; i++)
			rd(7'h76 + 7'(2 * i), scr[i]);
		// clock enable low: the write must not land
		ce = 1'b0;
		host.xfer(1'b1, 7'h76, ~scr[0][7:0], 1'b1, q, v);
		ce = 1'b1;
		rd(7'h76, scr[0]);
		wr(7'h72, ~`PRODUCT_CODE_VAL);
		wr(7'h7c, 16'hffff);
		rd(7'h72, `PRODUCT_CODE_VAL);
		rd(7'h7c, 16'h0000);
		wr(7'h68, 16'h00f7);
		check("busy", {15'h0, flash_busy}, 16'h0000);
		update(1'b1);
		update(1'b0);
		// mid-run reset clears scratch, count and outcome
		rst_b = 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		rst_b = 1'b1;
		cnt = 0;
		rd(7'h7c, cnt[15:0]);
		rd(7'h76, 16'h0000);
		rd(7'h5c, 16'h0000);
		end_of_test;
	end
endmodule
